/* File: pkg/fvt_pkg.sv */
// Constants and carrier types for the frequency and input threshold register bank
package fvt_pkg;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD = 8'h36;
  localparam int MANT_W = 4;
  localparam int UPPER_LSB = 4;
  localparam logic [11:0] FREQ_UPPER = 12'h380;
  localparam logic [11:0] VIN_UPPER = 12'h000;
  localparam logic [3:0] FREQ_MANT_RST = 4'h7;
  localparam logic [3:0] INPUT_TURN_ON_THRESHOLD_MANT_RST = 4'hA;
  localparam logic [3:0] INPUT_TURN_OFF_THRESHOLD_MANT_RST = 4'h9;
  localparam logic [3:0] STRAP_MANT_0 = 4'h4;
  localparam logic [3:0] STRAP_MANT_1 = 4'h6;
  localparam logic [3:0] STRAP_MANT_2 = 4'h7;
  localparam logic [3:0] STRAP_MANT_3 = 4'hA;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } fvt_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } fvt_rsp_t;

  typedef struct packed {
    logic [3:0] freq;
    logic [3:0] input_turn_on_threshold;
    logic [3:0] input_turn_off_threshold;
  } fvt_mant_t;
endpackage

/* File: core/fvt_regs.sv */
// Switching frequency and input turn-on/turn-off threshold registers with conversion gating
`timescale 1ns/10ps
module fvt_regs
(
  input wire logic clk,
  input wire logic nrst,
  input fvt_pkg::fvt_cmd_t cmd,
  input wire logic use_strap,
  input wire logic [1:0] frequency_strap_pin,
  input fvt_pkg::fvt_mant_t nvm_mant,
  input wire logic nvm_restore,
  input wire logic [15:0] power_input_voltage,
  input wire logic enable_conditions_met,
  input wire logic status_clear,
  output fvt_pkg::fvt_rsp_t rsp,
  output logic [11:0] freq_khz,
  output logic [15:0] input_turn_on_threshold_mv,
  output logic [15:0] input_turn_off_threshold_mv,
  output logic conversion_on,
  output logic input_undervoltage_flag,
  output logic invalid_data_flag,
  output logic host_notify
);
  import fvt_pkg::*;

  fvt_mant_t mant_q;
  logic load_pending_q;
  fvt_rsp_t rsp_q;
  logic [11:0] freq_khz_q;
  logic [15:0] input_turn_on_threshold_mv_q;
  logic [15:0] input_turn_off_threshold_mv_q;
  logic conv_q;
  logic uv_flag_q;
  logic uv_masked_q;
  logic invalid_q;
  logic notify_q;
  logic wr_ok;
  logic wr_bad;
  logic [3:0] strap_mant;

  function automatic logic mapped(input logic [7:0] code);
    return code == CMD_FREQ || code == CMD_INPUT_TURN_ON_THRESHOLD || code == CMD_INPUT_TURN_OFF_THRESHOLD;
  endfunction

  function automatic logic word_ok(input logic [7:0] code, input logic [15:0] w);
    if (code == CMD_FREQ)
      return w[15:UPPER_LSB] == FREQ_UPPER;
    return mapped(code) && w[15:UPPER_LSB] == VIN_UPPER;
  endfunction

  function automatic logic [11:0] freq_dec(input logic [3:0] m);
    logic [11:0] f;
    f = 12'h190;
    if (m == 4'hF) f = 12'h7D0;
    else if (m >= 4'hD) f = 12'h708;
    else if (m >= 4'hA) f = 12'h578;
    else if (m == 4'h9) f = 12'h4B0;
    else if (m >= 4'h7) f = 12'h3E8;
    else if (m == 4'h6) f = 12'h320;
    else if (m >= 4'h4) f = 12'h258;
    return f;
  endfunction

  function automatic logic [15:0] on_dec(input logic [3:0] m);
    logic [15:0] v;
    v = 16'h09C4;
    if (m >= 4'hA) v = 16'h2710;
    else if (m >= 4'h5) v = 16'(m) * 16'h03E8;
    else if (m >= 4'h3) v = 16'h0ED8;
    return v;
  endfunction

  function automatic logic [15:0] off_dec(input logic [3:0] m);
    logic [15:0] v;
    v = 16'h08FC;
    if (m >= 4'hA) v = 16'h251C;
    else if (m >= 4'h6) v = 16'(m) * 16'h03E8 - 16'h01F4;
    else if (m == 4'h5) v = 16'h1068;
    else if (m >= 4'h3) v = 16'h0E10;
    return v;
  endfunction

  assign wr_ok = cmd.wr && word_ok(cmd.code, cmd.wdata);
  assign wr_bad = cmd.wr && !word_ok(cmd.code, cmd.wdata);

  // Strap decode limited to four supported settings
  always_comb
  begin
    unique case (frequency_strap_pin)
      2'h0: strap_mant = STRAP_MANT_0;
      2'h1: strap_mant = STRAP_MANT_1;
      2'h2: strap_mant = STRAP_MANT_2;
      2'h3: strap_mant = STRAP_MANT_3;
    endcase
  end

  // Initial load on the first clock edge after reset release
  always_ff @(posedge clk)
  begin
    load_pending_q <= !nrst;
  end

  // Mantissa storage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mant_q.freq <= FREQ_MANT_RST;
      mant_q.input_turn_on_threshold <= INPUT_TURN_ON_THRESHOLD_MANT_RST;
      mant_q.input_turn_off_threshold <= INPUT_TURN_OFF_THRESHOLD_MANT_RST;
    end
    else if (load_pending_q || nvm_restore)
    begin
      mant_q.freq <= use_strap ? strap_mant : nvm_mant.freq;
      mant_q.input_turn_on_threshold <= nvm_mant.input_turn_on_threshold;
      mant_q.input_turn_off_threshold <= nvm_mant.input_turn_off_threshold;
    end
    else if (wr_ok)
    begin
      if (cmd.code == CMD_FREQ)
        mant_q.freq <= cmd.wdata[MANT_W-1:0];
      if (cmd.code == CMD_INPUT_TURN_ON_THRESHOLD)
        mant_q.input_turn_on_threshold <= cmd.wdata[MANT_W-1:0];
      if (cmd.code == CMD_INPUT_TURN_OFF_THRESHOLD)
        mant_q.input_turn_off_threshold <= cmd.wdata[MANT_W-1:0];
    end
  end

  // Read path with fixed upper bits
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= cmd.rd;
      if (cmd.rd && cmd.code == CMD_FREQ)
        rsp_q.rdata <= {FREQ_UPPER, mant_q.freq};
      else if (cmd.rd && cmd.code == CMD_INPUT_TURN_ON_THRESHOLD)
        rsp_q.rdata <= {VIN_UPPER, mant_q.input_turn_on_threshold};
      else if (cmd.rd && cmd.code == CMD_INPUT_TURN_OFF_THRESHOLD)
        rsp_q.rdata <= {VIN_UPPER, mant_q.input_turn_off_threshold};
      else
        rsp_q.rdata <= 16'h0000;
    end
  end

  // Decoded settings
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      freq_khz_q <= freq_dec(FREQ_MANT_RST);
      input_turn_on_threshold_mv_q <= on_dec(INPUT_TURN_ON_THRESHOLD_MANT_RST);
      input_turn_off_threshold_mv_q <= off_dec(INPUT_TURN_OFF_THRESHOLD_MANT_RST);
    end
    else
    begin
      freq_khz_q <= freq_dec(mant_q.freq);
      input_turn_on_threshold_mv_q <= on_dec(mant_q.input_turn_on_threshold);
      input_turn_off_threshold_mv_q <= off_dec(mant_q.input_turn_off_threshold);
    end
  end

  // Invalid data status and host notification
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      invalid_q <= 1'b0;
      notify_q <= 1'b0;
    end
    else
    begin
      notify_q <= wr_bad;
      if (wr_bad)
        invalid_q <= 1'b1;
      else if (status_clear)
        invalid_q <= 1'b0;
    end
  end

  // Conversion gating
  always_ff @(posedge clk)
  begin
    if (!nrst)
      conv_q <= 1'b0;
    else if (!enable_conditions_met)
      conv_q <= 1'b0;
    else if (conv_q && power_input_voltage < input_turn_off_threshold_mv_q)
      conv_q <= 1'b0;
    else if (!conv_q && power_input_voltage >= input_turn_on_threshold_mv_q)
      conv_q <= 1'b1;
  end

  // Undervoltage mask, cleared once, re-armed only by reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
      uv_masked_q <= 1'b1;
    else if (power_input_voltage > input_turn_on_threshold_mv_q)
      uv_masked_q <= 1'b0;
  end

  // Undervoltage flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      uv_flag_q <= 1'b0;
    else if (enable_conditions_met && !uv_masked_q && power_input_voltage < input_turn_off_threshold_mv_q)
      uv_flag_q <= 1'b1;
    else if (status_clear)
      uv_flag_q <= 1'b0;
  end

  assign rsp = rsp_q;
  assign freq_khz = freq_khz_q;
  assign input_turn_on_threshold_mv = input_turn_on_threshold_mv_q;
  assign input_turn_off_threshold_mv = input_turn_off_threshold_mv_q;
  assign conversion_on = conv_q;
  assign input_undervoltage_flag = uv_flag_q;
  assign invalid_data_flag = invalid_q;
  assign host_notify = notify_q;

  property p_freq_read;
    @(posedge clk) disable iff (!nrst)
    cmd.rd && cmd.code == CMD_FREQ |=> rsp.valid && rsp.rdata[15:4] == 12'h380;
  endproperty
  a_freq_read: assert property (p_freq_read) else $error("frequency fixed bits wrong");

  property p_vin_read;
    @(posedge clk) disable iff (!nrst)
    cmd.rd && (cmd.code == CMD_INPUT_TURN_ON_THRESHOLD || cmd.code == CMD_INPUT_TURN_OFF_THRESHOLD) |=> rsp.rdata[15:4] == 12'h000;
  endproperty
  a_vin_read: assert property (p_vin_read) else $error("threshold fixed bits wrong");

  property p_bad_write;
    @(posedge clk) disable iff (!nrst)
    cmd.wr && mapped(cmd.code) && !word_ok(cmd.code, cmd.wdata) && !load_pending_q && !nvm_restore
      |=> $stable(mant_q) && invalid_data_flag && host_notify;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("invalid write not rejected");

  property p_good_write;
    @(posedge clk) disable iff (!nrst)
    cmd.wr && cmd.code == CMD_FREQ && cmd.wdata[15:4] == 12'h380 && !load_pending_q && !nvm_restore
      |=> mant_q.freq == $past(cmd.wdata[3:0]) ##1 freq_khz == freq_dec($past(mant_q.freq));
  endproperty
  a_good_write: assert property (p_good_write) else $error("frequency write not applied");

  property p_strap_load;
    @(posedge clk) disable iff (!nrst)
    (load_pending_q || nvm_restore) && use_strap
      |=> ##1 (freq_khz == 12'h258 || freq_khz == 12'h320 || freq_khz == 12'h3E8 || freq_khz == 12'h578);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap frequency unsupported");

  property p_conv_start;
    @(posedge clk) disable iff (!nrst)
    $rose(conversion_on) |-> $past(power_input_voltage) >= $past(input_turn_on_threshold_mv) && $past(enable_conditions_met);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion started below threshold");

  property p_uv_masked;
    @(posedge clk) disable iff (!nrst)
    $rose(input_undervoltage_flag) |-> !$past(uv_masked_q);
  endproperty
  a_uv_masked: assert property (p_uv_masked) else $error("flag set while masked");

  property p_conv_stop;
    @(posedge clk) disable iff (!nrst)
    conversion_on && enable_conditions_met && power_input_voltage < input_turn_off_threshold_mv && !uv_masked_q
      |=> !conversion_on && input_undervoltage_flag;
  endproperty
  a_conv_stop: assert property (p_conv_stop) else $error("low input did not stop conversion");

  property p_mask_once;
    @(posedge clk) disable iff (!nrst)
    !uv_masked_q |=> !uv_masked_q;
  endproperty
  a_mask_once: assert property (p_mask_once) else $error("mask re-armed without reset");

endmodule // fvt_regs

/* File: verif/fvt_host.sv */
// Host model issuing command pulses and collecting read words
`timescale 1ns/10ps
module fvt_host
  import fvt_pkg::*;
(
  input wire logic clk,
  output fvt_pkg::fvt_cmd_t cmd,
  input fvt_pkg::fvt_rsp_t rsp
);
  initial cmd = '0;
  // One-cycle write pulse
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd <= '{wr: 1'b1, rd: 1'b0, code: code, wdata: data};
    @(posedge clk);
    cmd <= '0;
  endtask
  // Read pulse, answer one cycle later
  task automatic rd(input logic [7:0] code, output fvt_pkg::fvt_rsp_t r);
    @(posedge clk);
    cmd <= '{wr: 1'b0, rd: 1'b1, code: code, wdata: 16'h0000};
    @(posedge clk);
    cmd <= '0;
    #1 r = rsp;
  endtask
  // Turn-off first, turn-on kept above it
  task automatic set_th(input logic [3:0] on_m, input logic [3:0] off_m);
    wr(CMD_INPUT_TURN_OFF_THRESHOLD, {VIN_UPPER, off_m});
    wr(CMD_INPUT_TURN_ON_THRESHOLD, {VIN_UPPER, on_m});
  endtask
endmodule // fvt_host

/* File: verif/testbench.sv */
// Self-checking bench for the frequency and input threshold registers
`timescale 1ns/10ps
module testbench;
  import fvt_pkg::*;
  logic clk, nrst, use_strap, nvm_restore, en, status_clear;
  logic [1:0] frequency_strap_pin;
  logic [15:0] vin, input_turn_on_threshold_mv, input_turn_off_threshold_mv;
  logic [11:0] freq_khz;
  logic conversion_on, input_undervoltage_flag, invalid_data_flag, host_notify;
  fvt_cmd_t cmd;
  fvt_rsp_t rsp, r;
  fvt_mant_t nvm_mant;
  int failures = 0;
  int samples_checked = 0;
  logic [15:0] f_tab [16] = '{16'h0190, 16'h0190, 16'h0190, 16'h0190, 16'h0258, 16'h0258, 16'h0320, 16'h03E8,
    16'h03E8, 16'h04B0, 16'h0578, 16'h0578, 16'h0578, 16'h0708, 16'h0708, 16'h07D0};
  logic [15:0] on_tab [16] = '{16'h09C4, 16'h09C4, 16'h09C4, 16'h0ED8, 16'h0ED8, 16'h1388, 16'h1770, 16'h1B58,
    16'h1F40, 16'h2328, 16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h2710, 16'h2710};
  logic [15:0] off_tab [16] = '{16'h08FC, 16'h08FC, 16'h08FC, 16'h0E10, 16'h0E10, 16'h1068, 16'h157C, 16'h1964,
    16'h1D4C, 16'h2134, 16'h251C, 16'h251C, 16'h251C, 16'h251C, 16'h251C, 16'h251C};
  logic [3:0] s_tab [4] = '{4'h4, 4'h6, 4'h7, 4'hA};

  fvt_regs uut (.clk(clk), .nrst(nrst), .cmd(cmd), .use_strap(use_strap),
    .frequency_strap_pin(frequency_strap_pin), .nvm_mant(nvm_mant), .nvm_restore(nvm_restore),
    .power_input_voltage(vin), .enable_conditions_met(en), .status_clear(status_clear), .rsp(rsp),
    .freq_khz(freq_khz), .input_turn_on_threshold_mv(input_turn_on_threshold_mv), .input_turn_off_threshold_mv(input_turn_off_threshold_mv), .conversion_on(conversion_on),
    .input_undervoltage_flag(input_undervoltage_flag), .invalid_data_flag(invalid_data_flag),
    .host_notify(host_notify));
  fvt_host host (.clk(clk), .cmd(cmd), .rsp(rsp));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    step(3);
  endtask

  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0;
    use_strap = 1'b0;
    nvm_restore = 1'b0;
    en = 1'b0;
    status_clear = 1'b0;
    frequency_strap_pin = 2'h0;
    vin = 16'h0000;
    nvm_mant = '{freq: 4'hD, input_turn_on_threshold: 4'h8, input_turn_off_threshold: 4'h6};
    do_reset();
    host.rd(CMD_FREQ, r);
    chk(r.rdata, 16'h380D);
    host.rd(CMD_INPUT_TURN_ON_THRESHOLD, r);
    chk(r.rdata, 16'h0008);
    host.rd(CMD_INPUT_TURN_OFF_THRESHOLD, r);
    chk(r.rdata, 16'h0006);
    chk({4'h0, freq_khz}, 16'h0708);
    // Every mantissa through all three words
    for (int m = 0; m < 16; m++)
    begin
      host.wr(CMD_FREQ, {FREQ_UPPER, 4'(m)});
      host.wr(CMD_INPUT_TURN_ON_THRESHOLD, {VIN_UPPER, 4'(m)});
      host.wr(CMD_INPUT_TURN_OFF_THRESHOLD, {VIN_UPPER, 4'(m)});
      step(2);
      chk({4'h0, freq_khz}, f_tab[m]);
      chk(input_turn_on_threshold_mv, on_tab[m]);
      chk(input_turn_off_threshold_mv, off_tab[m]);
      host.rd(CMD_INPUT_TURN_OFF_THRESHOLD, r);
      chk({r.valid, r.rdata[14:0]}, {1'b1, 11'h000, 4'(m)});
    end
    // Strap codes on restore
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      use_strap <= 1'b1;
      frequency_strap_pin <= 2'(s);
      nvm_restore <= 1'b1;
      @(posedge clk);
      nvm_restore <= 1'b0;
      host.rd(CMD_FREQ, r);
      chk(r.rdata, {FREQ_UPPER, s_tab[s]});
    end
    // Refused mapped write, then unmapped read
    host.wr(CMD_FREQ, 16'h0005);
    #1;
    chk({host_notify, invalid_data_flag}, 16'h0003);
    step(1);
    chk({host_notify, invalid_data_flag}, 16'h0001);
    host.rd(CMD_FREQ, r);
    chk(r.rdata, 16'h380A);
    host.rd(8'h34, r);
    chk(r.rdata, 16'h0000);
    // Undervoltage mask and conversion gating
    host.set_th(4'h8, 4'h6);
    @(posedge clk);
    en <= 1'b1;
    vin <= 16'h1388;
    step(4);
    chk({conversion_on, input_undervoltage_flag}, 16'h0000);
    @(posedge clk);
    vin <= 16'h2134;
    step(4);
    chk({conversion_on, input_undervoltage_flag}, 16'h0002);
    @(posedge clk);
    vin <= 16'h1388;
    step(4);
    chk({conversion_on, input_undervoltage_flag}, 16'h0001);
    @(posedge clk);
    en <= 1'b0;
    nvm_restore <= 1'b1;
    status_clear <= 1'b1;
    @(posedge clk);
    en <= 1'b1;
    nvm_restore <= 1'b0;
    status_clear <= 1'b0;
    step(4);
    chk({invalid_data_flag, input_undervoltage_flag}, 16'h0001);
    // Unmapped write, then clear against a standing undervoltage
    host.wr(8'h34, 16'h0000);
    #1;
    chk({host_notify, invalid_data_flag}, 16'h0003);
    @(posedge clk);
    status_clear <= 1'b1;
    @(posedge clk);
    status_clear <= 1'b0;
    step(1);
    chk({invalid_data_flag, input_undervoltage_flag}, 16'h0001);
    do_reset();
    step(4);
    chk({conversion_on, input_undervoltage_flag}, 16'h0000);
    report_and_stop();
  end
endmodule // testbench
